// ---- oaf_params.svh ----
// Constants for the operand address and flag unit.
// Assumes a 16-bit address space and an 8-bit data path.
`ifndef OAF_PARAMS_SVH
`define OAF_PARAMS_SVH

`define OAF_ADDR_W      16
`define OAF_DATA_W      8
`define OAF_DIRECT_PAGE 8'h00
`define OAF_INCR        16'h0001
`define OAF_ZERO16      16'h0000
`define OAF_ZERO8       8'h00
`define OAF_MSB8        7
`define OAF_FLAG_C      0
`define OAF_FLAG_Z      1
`define OAF_FLAG_N      2
`define OAF_FLAGS_RST   3'h0

`endif

// ---- oaf_pkg.sv ----
// Types for the operand address and flag unit.
// Assumes the macros of oaf_params.svh.
package oaf_pkg;

  typedef enum logic [3:0] {
    register_only_mode       = 4'h0,
    branch_offset_mode       = 4'h1,
    literal_operand_mode     = 4'h2,
    direct_page_mode         = 4'h3,
    full_address_mode        = 4'h4,
    pair_only_mode           = 4'h5,
    pair_post_incr_mode      = 4'h6,
    pair_plus_byte_mode      = 4'h7,
    pair_plus_byte_incr_mode = 4'h8,
    pair_plus_word_mode      = 4'h9,
    stack_plus_byte_mode     = 4'ha,
    stack_plus_word_mode     = 4'hb
  } oaf_mode_t;

  typedef enum logic [2:0] {
    OAF_FL_NONE  = 3'h0,
    OAF_FL_ADD   = 3'h1,
    OAF_FL_SUB   = 3'h2,
    OAF_FL_MOVE  = 3'h3,
    OAF_FL_LOGIC = 3'h4,
    OAF_FL_CSET  = 3'h5
  } oaf_flag_op_t;

endpackage

// ---- oaf_core.sv ----
// Operand effective address and result flag unit of an 8-bit core.
// Assumes mode, operand bytes and results come from the sequencer
// in the same cycle as the request strobe.
//
// Behaviour
// [RQ1] Zero flag set for 8- or 16-bit all-zero result, cleared otherwise.
// [RQ2] Plain load or store also updates zero flag from transferred value.
// [RQ3] Carry set on carry out of bit 7 or subtract borrow.
// [RQ4] Bit-test branch, shift and rotate also drive the carry flag.
// [RQ5] Every location reached by one unique 16-bit address.
// [RQ6] Copy uses independent source and destination modes.
// [RQ7] Test ops fetch operand by listed mode; branch target always relative.
// [RQ8] Register-only mode performs no operand memory access.
// [RQ9] Relative: signed byte sign-extended, added to counter when taken.
// [RQ10] Literal operand follows opcode, high byte first for 16 bits.
// [RQ11] Direct mode: implied high byte 0x00 above address byte.
// [RQ12] Full-address mode: 16-bit address from two bytes, high first.
// [RQ13] Pair-only mode uses index pair directly as address.
// [RQ14] Pair post increment: pair is address, then pair plus one.
// [RQ15] Pair plus unsigned byte offset forms the address.
// [RQ16] Pair plus byte, then pair incremented by one after fetch.
// [RQ17] Pair plus 16-bit offset forms the address.
// [RQ18] Stack pointer plus unsigned byte offset forms the address.
// [RQ19] Stack pointer plus 16-bit offset forms the address.
// [RQ20] Negative flag follows result bit 7; code takes bit 15 for 16-bit results.
// [RQ21] Address sums and increments wrap at 16 bits, no flag.
`include "oaf_params.svh"
`timescale 1ns/1ns
`default_nettype none

module oaf_core #(
  parameter int AW = `OAF_ADDR_W,
  parameter int DW = `OAF_DATA_W
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // Address request
  input  wire logic              addrReq,
  input  wire oaf_pkg::oaf_mode_t srcMode,
  input  wire oaf_pkg::oaf_mode_t dstMode,
  input  wire logic              copyOp,
  input  wire logic [DW-1:0]     opByteHi,
  input  wire logic [DW-1:0]     opByteLo,
  input  wire logic [AW-1:0]     indexPair,
  input  wire logic [AW-1:0]     stack_pointer,
  input  wire logic [AW-1:0]     program_counter,
  input  wire logic              branchTaken,
  // Flag request
  input  wire logic              flagReq,
  input  wire oaf_pkg::oaf_flag_op_t flagOp,
  input  wire logic              wideResult,
  input  wire logic [AW-1:0]     result,
  input  wire logic              carryIn,
  // Address answer
  output logic                   addrValid,
  output logic [AW-1:0]          srcAddr,
  output logic                   srcMemAccess,
  output logic [AW-1:0]          dstAddr,
  output logic                   dstMemAccess,
  output logic [AW-1:0]          nextIndexPair,
  output logic                   indexUpdate,
  output logic [AW-1:0]          branchTarget,
  output logic                   branchLoad,
  // Flags
  output logic [2:0]             flag_register
);
  import oaf_pkg::*;

  // ==========================================
  // Effective address formation
  // ==========================================
  function automatic logic [AW-1:0] calcAddr(
    input oaf_mode_t m,
    input logic [DW-1:0] hi,
    input logic [DW-1:0] lo,
    input logic [AW-1:0] pair,
    input logic [AW-1:0] sp,
    input logic [AW-1:0] pc
  );
    logic [AW-1:0] wordOff;
    logic [AW-1:0] byteOff;
    wordOff = {hi, lo};                              // [RQ10] [RQ12]
    byteOff = {{(AW-DW){1'b0}}, lo};
    case (m)
      literal_operand_mode:     calcAddr = pc;       // [RQ10]
      direct_page_mode:         calcAddr = {`OAF_DIRECT_PAGE, lo}; // [RQ11]
      full_address_mode:        calcAddr = wordOff;  // [RQ12] [RQ5]
      pair_only_mode:           calcAddr = pair;     // [RQ13]
      pair_post_incr_mode:      calcAddr = pair;     // [RQ14]
      pair_plus_byte_mode:      calcAddr = AW'(pair + byteOff); // [RQ15] [RQ21]
      pair_plus_byte_incr_mode: calcAddr = AW'(pair + byteOff); // [RQ16] [RQ21]
      pair_plus_word_mode:      calcAddr = AW'(pair + wordOff); // [RQ17] [RQ21]
      stack_plus_byte_mode:     calcAddr = AW'(sp + byteOff);   // [RQ18] [RQ21]
      stack_plus_word_mode:     calcAddr = AW'(sp + wordOff);   // [RQ19] [RQ21]
      default:                  calcAddr = `OAF_ZERO16;
    endcase
  endfunction

  function automatic logic needsMem(input oaf_mode_t m);
    case (m)
      register_only_mode: needsMem = 1'b0;  // [RQ8]
      branch_offset_mode: needsMem = 1'b0;
      default:            needsMem = 1'b1;
    endcase
  endfunction

  function automatic logic postIncr(input oaf_mode_t m);
    postIncr = (m == pair_post_incr_mode) ||
               (m == pair_plus_byte_incr_mode);
  endfunction

  logic [AW-1:0] relOffset;
  assign relOffset = {{(AW-DW){opByteLo[`OAF_MSB8]}}, opByteLo}; // [RQ9]

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      addrValid <= 1'b0;
    end else begin
      addrValid <= addrReq;
    end
  end

  // Source operand; tested operand for branch-on-test ops
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      srcAddr      <= `OAF_ZERO16;
      srcMemAccess <= 1'b0;
    end else if (addrReq) begin
      srcAddr      <= calcAddr(srcMode, opByteHi, opByteLo, indexPair,
                               stack_pointer, program_counter); // [RQ7]
      srcMemAccess <= needsMem(srcMode);                        // [RQ8]
    end else begin
      srcMemAccess <= 1'b0;
    end
  end

  // Independent destination for copy
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dstAddr      <= `OAF_ZERO16;
      dstMemAccess <= 1'b0;
    end else if (addrReq && copyOp) begin
      dstAddr      <= calcAddr(dstMode, opByteHi, opByteLo, indexPair,
                               stack_pointer, program_counter); // [RQ6]
      dstMemAccess <= needsMem(dstMode);
    end else begin
      dstMemAccess <= 1'b0;
    end
  end

  // Index pair post increment
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      nextIndexPair <= `OAF_ZERO16;
      indexUpdate   <= 1'b0;
    end else begin
      nextIndexPair <= AW'(indexPair + `OAF_INCR); // [RQ14] [RQ16] [RQ21]
      indexUpdate   <= addrReq &&
                       (postIncr(srcMode) || (copyOp && postIncr(dstMode)));
    end
  end

  // Relative branch target
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      branchTarget <= `OAF_ZERO16;
      branchLoad   <= 1'b0;
    end else begin
      branchTarget <= AW'(program_counter + relOffset); // [RQ9] [RQ21]
      branchLoad   <= addrReq && branchTaken;           // [RQ7] [RQ9]
    end
  end

  // ==========================================
  // Result flags
  // ==========================================
  logic resZero;
  assign resZero = wideResult ? (result == `OAF_ZERO16)
                              : (result[DW-1:0] == `OAF_ZERO8);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_register <= `OAF_FLAGS_RST;
    end else if (flagReq) begin
      case (flagOp)
        OAF_FL_ADD, OAF_FL_SUB, OAF_FL_CSET: begin
          flag_register[`OAF_FLAG_Z] <= resZero;              // [RQ1]
          flag_register[`OAF_FLAG_N] <= wideResult ?
            result[AW-1] : result[`OAF_MSB8];                 // [RQ20]
          flag_register[`OAF_FLAG_C] <= carryIn;              // [RQ3] [RQ4]
        end
        OAF_FL_MOVE, OAF_FL_LOGIC: begin
          flag_register[`OAF_FLAG_Z] <= resZero;              // [RQ1] [RQ2]
          flag_register[`OAF_FLAG_N] <= wideResult ?
            result[AW-1] : result[`OAF_MSB8];                 // [RQ20]
        end
        default: begin
          flag_register <= flag_register;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- oaf_mem_model.sv ----
// Behavioural model of the 64-Kbyte memory space behind the unit.
// Assumes reads are issued by srcAddr while srcMemAccess pulses.
`timescale 1ns/1ns
`default_nettype none
module oaf_mem_model (
  // Clock and request
  input  wire logic        mclk,
  input  wire logic [15:0] srcAddr,
  input  wire logic        srcMemAccess,
  // Read data
  output var  logic [7:0]  memData = 8'h00
);
  logic [7:0] mem [0:65535];
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8));
  // Released bus inverts its previous output on every idle cycle
  always_ff @(posedge mclk) begin
    memData <= srcMemAccess ? mem[srcAddr] : ~memData;
  end
endmodule
`default_nettype wire

// ---- oaf_core_props.sv ----
// Concurrent checks on the ports of the operand address and flag unit.
// Assumes the single mclk domain with sys_rst as async reset.
`timescale 1ns/1ns
`default_nettype none
module oaf_core_props
  import oaf_pkg::*;
(
  input wire logic mclk, sys_rst, addrReq, branchTaken, flagReq,
  input wire oaf_pkg::oaf_mode_t srcMode,
  input wire logic [7:0] opByteHi, opByteLo,
  input wire logic [15:0] indexPair, program_counter, result,
  input wire oaf_pkg::oaf_flag_op_t flagOp,
  input wire logic wideResult, carryIn, addrValid, srcMemAccess,
  input wire logic indexUpdate, branchLoad,
  input wire logic [15:0] srcAddr, branchTarget,
  input wire logic [2:0] flag_register
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Answer follows every request by one cycle; back to back allowed
  property p_valid; addrValid == $past(addrReq); endproperty
  a_valid: assert property (p_valid) else $error("no answer");
  property p_inh; addrReq && srcMode == register_only_mode |=> !srcMemAccess;
  endproperty
  a_inh: assert property (p_inh) else $error("inh access");
  property p_dir; addrReq && srcMode == direct_page_mode
    |=> srcAddr == {8'h00, $past(opByteLo)}; endproperty
  a_dir: assert property (p_dir) else $error("direct addr");
  property p_ext; addrReq && srcMode == full_address_mode
    |=> srcAddr == {$past(opByteHi), $past(opByteLo)}; endproperty
  a_ext: assert property (p_ext) else $error("full addr");
  property p_ix1; addrReq && srcMode == pair_plus_byte_mode
    |=> srcAddr == 16'($past(indexPair) + $past(opByteLo)); endproperty
  a_ix1: assert property (p_ix1) else $error("pair byte");
  property p_inc; addrReq && srcMode == pair_post_incr_mode |=> indexUpdate;
  endproperty
  a_inc: assert property (p_inc) else $error("no incr");
  property p_br; addrReq && branchTaken |=> branchLoad; endproperty
  a_br: assert property (p_br) else $error("no branch");
  property p_tgt; !$past(sys_rst) |-> branchTarget == 16'($past(program_counter)
    + {{8{$past(opByteLo[7])}}, $past(opByteLo)}); endproperty
  a_tgt: assert property (p_tgt) else $error("target");
  property p_z; flagReq && flagOp != OAF_FL_NONE |=> flag_register[1] ==
    ($past(wideResult) ? $past(result) == 16'h0000
                       : $past(result[7:0]) == 8'h00); endproperty
  a_z: assert property (p_z) else $error("zero flag");
  property p_c; flagReq && flagOp inside {OAF_FL_ADD, OAF_FL_SUB, OAF_FL_CSET}
    |=> flag_register[0] == $past(carryIn); endproperty
  a_c: assert property (p_c) else $error("carry flag");
endmodule
bind oaf_core oaf_core_props i_oaf_core_props (.mclk, .sys_rst, .addrReq,
  .branchTaken, .flagReq, .srcMode, .opByteHi, .opByteLo, .indexPair,
  .program_counter, .result, .flagOp, .wideResult, .carryIn, .addrValid,
  .srcMemAccess, .indexUpdate, .branchLoad, .srcAddr, .branchTarget,
  .flag_register);
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench of the operand address and flag unit.
// Assumes oaf_core, oaf_mem_model and the checker are compiled before.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import oaf_pkg::*;
  typedef struct {oaf_mode_t m; logic [7:0] hi, lo; logic [15:0] a;
                  logic mem;} oaf_row_t;
  logic mclk = '0, sys_rst = '1, addrReq = '0, copyOp = '0, branchTaken = '0;
  logic flagReq = '0, wideResult = '0, carryIn = '0;
  oaf_mode_t srcMode = register_only_mode, dstMode = register_only_mode;
  oaf_flag_op_t flagOp = OAF_FL_NONE;
  logic [7:0] opByteHi = '0, opByteLo = '0, memData;
  logic [15:0] indexPair = 16'hfff0, stack_pointer = 16'h0100;
  logic [15:0] program_counter = 16'h8000, result = '0;
  logic addrValid, srcMemAccess, dstMemAccess, indexUpdate, branchLoad;
  logic [15:0] srcAddr, dstAddr, nextIndexPair, branchTarget;
  logic [2:0] flag_register;
  int errors = 0, n_tests = 0;
  oaf_row_t rows [12] = '{
    '{register_only_mode, 8'h12, 8'h34, 16'h0000, 1'b0},
    '{branch_offset_mode, 8'h12, 8'h34, 16'h0000, 1'b0},
    '{literal_operand_mode, 8'h12, 8'h34, 16'h8000, 1'b1},
    '{direct_page_mode, 8'h12, 8'h34, 16'h0034, 1'b1},
    '{full_address_mode, 8'h12, 8'h34, 16'h1234, 1'b1},
    '{pair_only_mode, 8'h12, 8'h34, 16'hfff0, 1'b1},
    '{pair_post_incr_mode, 8'h12, 8'h34, 16'hfff0, 1'b1},
    '{pair_plus_byte_mode, 8'h12, 8'h20, 16'h0010, 1'b1},
    '{pair_plus_byte_incr_mode, 8'h12, 8'hff, 16'h00ef, 1'b1},
    '{pair_plus_word_mode, 8'h12, 8'h34, 16'h1224, 1'b1},
    '{stack_plus_byte_mode, 8'h12, 8'hff, 16'h01ff, 1'b1},
    '{stack_plus_word_mode, 8'hff, 8'hff, 16'h00ff, 1'b1}};
  always #5 mclk = ~mclk;
  oaf_core i_oaf_core (.mclk, .sys_rst, .addrReq, .srcMode, .dstMode, .copyOp,
    .opByteHi, .opByteLo, .indexPair, .stack_pointer, .program_counter,
    .branchTaken, .flagReq, .flagOp, .wideResult, .result, .carryIn,
    .addrValid, .srcAddr, .srcMemAccess, .dstAddr, .dstMemAccess,
    .nextIndexPair, .indexUpdate, .branchTarget, .branchLoad, .flag_register);
  oaf_mem_model i_oaf_mem_model (.mclk, .srcAddr, .srcMemAccess, .memData);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic areq(input oaf_row_t r);
    @(posedge mclk) #1;
    {addrReq, srcMode, opByteHi, opByteLo} = {1'b1, r.m, r.hi, r.lo};
    @(posedge mclk) #1;
    addrReq = 1'b0;
  endtask
  task automatic freq(oaf_flag_op_t op, logic w, logic [15:0] res, logic c,
                      logic [2:0] e);
    @(posedge mclk) #1;
    {flagReq, flagOp, wideResult, result, carryIn} = {1'b1, op, w, res, c};
    @(posedge mclk) #1;
    flagReq = 1'b0;
    check(16'(flag_register), 16'(e));
  endtask
  task automatic stop_test;
    $display("Errors %0d of %0d checks", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge mclk);
    #1 check(16'(flag_register), 16'h0000);
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      areq(rows[i]);
      check(16'(addrValid), 16'h0001);
      check(16'(srcMemAccess), 16'(rows[i].mem));
      if (rows[i].mem) check(srcAddr, rows[i].a);
      @(posedge mclk) #1;
      if (rows[i].mem) check(16'(memData), 16'(rows[i].a[7:0] ^ rows[i].a[15:8]));
    end
    {copyOp, dstMode, indexPair, branchTaken} = {1'b1, pair_post_incr_mode,
                                                 16'hffff, 1'b1};
    areq('{direct_page_mode, 8'h00, 8'h80, 16'h0080, 1'b1});
    check(dstAddr, 16'hffff);
    check(16'(dstMemAccess), 16'h0001);
    check(16'(indexUpdate), 16'h0001);
    check(nextIndexPair, 16'h0000);
    check(16'(branchLoad), 16'h0001);
    check(branchTarget, 16'h7f80);
    copyOp = 1'b0;
    freq(OAF_FL_ADD, 1'b1, 16'h0000, 1'b1, 3'h3);
    freq(OAF_FL_SUB, 1'b0, 16'h0180, 1'b0, 3'h4);
    freq(OAF_FL_ADD, 1'b1, 16'h8000, 1'b0, 3'h4);
    freq(OAF_FL_LOGIC, 1'b0, 16'h0100, 1'b1, 3'h2);
    freq(OAF_FL_CSET, 1'b0, 16'h0001, 1'b1, 3'h1);
    freq(OAF_FL_NONE, 1'b0, 16'h0000, 1'b0, 3'h1);
    freq(OAF_FL_MOVE, 1'b0, 16'h0000, 1'b0, 3'h3);
    sys_rst = 1'b1;
    #10 check(16'(flag_register), 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
